//--- core/fcc_array.v
`timescale 1ns/1ns
`include "fcc_defines.vh"
// word array model with registered read data
module fcc_array (
    input  wire                pclk,
    input  wire                we,
    input  wire [`FCC_AW-1:0]  waddr,
    input  wire [15:0]         wdata,
    input  wire [`FCC_AW-1:0]  raddr,
    output reg  [15:0]         rdata
);
    reg [15:0] mem [0:`FCC_DEPTH-1];
    always @(posedge pclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule

//--- core/fcc_ctrl.v
// Contract
// - erase verify 0x05 sets blank flag only when every location reads erased
// - program 0x20 writes one word at captured address with captured data
// - sector erase 0x40 clears the sector, ignoring address bits 7:0 and data
// - mass erase 0x41 runs only if both disable bits and open bit set
// - erase verify stops at first non-erased word, blank stays clear
// - protected target sets protection violation and command does not launch
// - complete flag sets when operation and any buffered command finish
// - access error on array write before divider, misaligned, or buffer busy
// - access error on out-of-order writes or second or invalid command
// - access error on 0 to buffer-empty, stop during run, or secured non-mass
// - register reads never error; array reads during run give invalid data
// - access error locks launching until cleared
// - protection violation after word write or mass erase under protection
// - wait mode lets active and buffered commands complete
// - stop aborts, sets complete and error; exit sets empty, drops buffer
// - debug mode writes protection; secured special mode allows mass erase only
// - launch clears complete flag, then buffer-empty sets when buffers free
// - divider write sets loaded flag; commands without it give access error
// - interrupt when buffer-empty and enable, or complete and enable
//
// Design decisions made here: the placing of the registers and the APB slave port.
`timescale 1ns/1ns
`include "fcc_defines.vh"
module fcc_ctrl (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    input  wire [3:0]  pstrb,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire        stop_mode,
    input  wire        background_debug_mode,
    input  wire        secured,
    input  wire        special_single_chip,
    input  wire        secure_source,
    output wire        irq,
    output wire        high_voltage_on
);
    // command write sequence steps
    localparam S_IDLE = 2'd0;
    localparam S_ADDR = 2'd1;
    localparam S_CMD  = 2'd2;
    // engine: idle, timed program or erase, erase verify scan
    localparam E_IDLE = 2'd0;
    localparam E_RUN  = 2'd1;
    localparam E_VER  = 2'd2;

    reg [1:0]  seq_q;
    reg [1:0]  ex_q;
    reg [7:0]  div_q;
    reg        divld_q;
    reg [7:0]  cfg_q;
    reg [7:0]  prot_q;
    reg        bef_q;
    reg        ccf_q;
    reg        acc_q;
    reg        pvi_q;
    reg        blank_q;
    // buffer stage, filled by the write sequence
    reg [8:0]  baddr_q;
    reg [15:0] bdata_q;
    reg [7:0]  bcmd_q;
    reg        bvalid_q;
    // active stage, fed from the buffer
    reg [8:0]  aaddr_q;
    reg [15:0] adata_q;
    reg [7:0]  acmd_q;
    reg [15:0] tmr_q;
    reg [8:0]  ptr_q;
    reg        stop_q;
    reg        rd_ok_q;
    reg        rd_wait_q;

    wire acc   = psel & penable;
    wire rd_acc = acc & ~pwrite;
    wire wr    = acc & pwrite;
    wire arr   = paddr[11];
    wire [8:0] waddr = paddr[9:1];
    wire arr_wr = wr & arr;
    wire reg_wr = wr & ~arr;
    wire [7:0] wb = pwdata[7:0];
    wire cmd_ok = (wb == `FCC_CMD_VERIFY) | (wb == `FCC_CMD_PROG) |
                  (wb == `FCC_CMD_SECT) | (wb == `FCC_CMD_MASS);
    // protection: all guarded unless open; then low half unless low-disable, high half unless high-disable
    wire open_all = prot_q[`FCC_PR_OPEN] & prot_q[`FCC_PR_HDIS] & prot_q[`FCC_PR_LDIS];
    wire stat_wr = reg_wr & (paddr == `FCC_OFF_STAT);
    wire launch_req = stat_wr & wb[`FCC_ST_BEF] & (seq_q == S_CMD);
    wire busy = (ex_q != E_IDLE);
    wire stop_rise = stop_mode & ~stop_q;
    wire stop_fall = ~stop_mode & stop_q;

    // reads wait one cycle so the registered read data stands at the answer edge
    assign pready  = ~rd_acc | rd_wait_q;
    assign pslverr = 1'b0;
    assign high_voltage_on = (ex_q == E_RUN);
    assign irq = (bef_q & cfg_q[`FCC_CF_BEIE]) | (ccf_q & cfg_q[`FCC_CF_COMPLETE_IRQ_ENABLE]);

    reg        mem_we;
    reg [8:0]  mem_wa;
    reg [15:0] mem_wd;
    reg [8:0]  mem_ra;
    wire [15:0] mem_rd;

    fcc_array u_array (
        .pclk  (pclk),
        .we    (mem_we),
        .waddr (mem_wa),
        .wdata (mem_wd),
        .raddr (mem_ra),
        .rdata (mem_rd)
    );

    always @* begin
        mem_we = 1'b0;
        mem_wa = aaddr_q;
        mem_wd = 16'hFFFF;
        mem_ra = busy ? ptr_q : waddr;
        if (ex_q == E_RUN && tmr_q == 16'd0) begin
            if (acmd_q == `FCC_CMD_PROG) begin
                mem_we = 1'b1;
                mem_wd = adata_q & mem_rd;
            end else begin
                mem_we = 1'b1;
                mem_wa = ptr_q;
            end
        end
    end

    // erase runs word by word: sector spans 256 words, array all
    wire is_erase = (acmd_q == `FCC_CMD_SECT) | (acmd_q == `FCC_CMD_MASS);
    wire [8:0] erase_end = (acmd_q == `FCC_CMD_SECT) ? {aaddr_q[8], 8'hFF} : 9'h1FF;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seq_q <= S_IDLE;
            ex_q <= E_IDLE;
            div_q <= 8'h00;
            divld_q <= 1'b0;
            cfg_q <= 8'h00;
            prot_q <= `FCC_PROT_RST;
            bef_q <= 1'b1;
            ccf_q <= 1'b1;
            acc_q <= 1'b0;
            pvi_q <= 1'b0;
            blank_q <= 1'b0;
            baddr_q <= 9'h000;
            bdata_q <= 16'h0000;
            bcmd_q <= 8'h00;
            bvalid_q <= 1'b0;
            aaddr_q <= 9'h000;
            adata_q <= 16'h0000;
            acmd_q <= 8'h00;
            tmr_q <= 16'h0000;
            ptr_q <= 9'h000;
            stop_q <= 1'b0;
            rd_ok_q <= 1'b0;
            rd_wait_q <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            stop_q <= stop_mode;
            rd_wait_q <= rd_acc & ~rd_wait_q;
            // registers
            if (reg_wr && paddr == `FCC_OFF_DIV && !divld_q) begin
                div_q <= wb;
                divld_q <= 1'b1;
            end
            if (reg_wr && paddr == `FCC_OFF_CFG) cfg_q <= wb;
            if (reg_wr && paddr == `FCC_OFF_PROT && (background_debug_mode || prot_q != 8'h00))
                prot_q <= background_debug_mode ? wb : (prot_q & wb);
            if (stat_wr) begin
                if (wb[`FCC_ST_ACCESS_ERROR_FLAG]) acc_q <= 1'b0;
                if (wb[`FCC_ST_PROTECTION_VIOLATION_FLAG])  pvi_q <= 1'b0;
            end
            // sequence tracking
            if (arr_wr) begin
                if (!divld_q || paddr[0] || pstrb != 4'b0011 || !bef_q || seq_q != S_IDLE
                    || acc_q || pvi_q) begin
                    acc_q <= 1'b1;
                    seq_q <= S_IDLE;
                end else begin
                    baddr_q <= waddr;
                    bdata_q <= pwdata[15:0];
                    seq_q <= S_ADDR;
                end
            end else if (reg_wr && seq_q == S_ADDR) begin
                if (paddr != `FCC_OFF_CMD || !cmd_ok) begin
                    acc_q <= 1'b1;
                    seq_q <= S_IDLE;
                end else if (secured && wb != `FCC_CMD_MASS &&
                             (!secure_source || background_debug_mode || special_single_chip)) begin
                    acc_q <= 1'b1;
                    seq_q <= S_IDLE;
                end else if ((wb == `FCC_CMD_MASS && !open_all) ||
                             ((wb == `FCC_CMD_PROG || wb == `FCC_CMD_SECT) && addr_prot_b(baddr_q, prot_q))) begin
                    pvi_q <= 1'b1;
                    seq_q <= S_IDLE;
                end else begin
                    bcmd_q <= wb;
                    seq_q <= S_CMD;
                end
            end else if (reg_wr && seq_q == S_CMD) begin
                if (!stat_wr) begin
                    acc_q <= 1'b1;
                    seq_q <= S_IDLE;
                end else if (!wb[`FCC_ST_BEF]) begin
                    acc_q <= 1'b1;
                    seq_q <= S_IDLE;
                end else if (!acc_q && !pvi_q) begin
                    bvalid_q <= 1'b1;
                    bef_q <= 1'b0;
                    ccf_q <= 1'b0;
                    seq_q <= S_IDLE;
                end
            end
            // execution: buffered command moves to active stage
            if (bvalid_q && !busy && !launch_req) begin
                aaddr_q <= baddr_q;
                adata_q <= bdata_q;
                acmd_q <= bcmd_q;
                bvalid_q <= 1'b0;
                bef_q <= 1'b1;
                blank_q <= 1'b0;
                ptr_q <= (bcmd_q == `FCC_CMD_SECT) ? {baddr_q[8], 8'h00} :
                         (bcmd_q == `FCC_CMD_PROG) ? baddr_q : 9'h000;
                tmr_q <= (bcmd_q == `FCC_CMD_PROG) ? `FCC_T_PROG :
                         (bcmd_q == `FCC_CMD_SECT) ? `FCC_T_SECT : `FCC_T_MASS;
                ex_q <= (bcmd_q == `FCC_CMD_VERIFY) ? E_VER : E_RUN;
                rd_ok_q <= 1'b0;
            end else if (ex_q == E_VER) begin
                rd_ok_q <= 1'b1;
                if (rd_ok_q && mem_rd != 16'hFFFF) begin
                    ex_q <= E_IDLE;
                    if (!bvalid_q) ccf_q <= 1'b1;
                // pointer runs one word ahead of the data: a wrap means the last word was checked
                end else if (rd_ok_q && ptr_q == 9'h000) begin
                    blank_q <= 1'b1;
                    ex_q <= E_IDLE;
                    if (!bvalid_q) ccf_q <= 1'b1;
                end else begin
                    ptr_q <= ptr_q + 9'd1;
                end
            end else if (ex_q == E_RUN) begin
                // wait mode does not pause the engine
                if (tmr_q != 16'd0) begin
                    tmr_q <= tmr_q - 16'd1;
                end else if (is_erase && ptr_q != erase_end) begin
                    ptr_q <= ptr_q + 9'd1;
                end else begin
                    ex_q <= E_IDLE;
                    if (!bvalid_q) ccf_q <= 1'b1;
                end
            end
            if (stop_rise && (busy || bvalid_q)) begin
                ex_q <= E_IDLE;
                bvalid_q <= 1'b0;
                ccf_q <= 1'b1;
                acc_q <= 1'b1;
            end
            if (stop_fall) begin
                bef_q <= 1'b1;
                bvalid_q <= 1'b0;
            end
            // read mux; array reads while busy give invalid data
            if (rd_acc && !rd_wait_q) begin
                case (paddr)
                    `FCC_OFF_DIV:  prdata <= {23'h000000, divld_q, div_q};
                    `FCC_OFF_CFG:  prdata <= {24'h000000, cfg_q};
                    `FCC_OFF_PROT: prdata <= {24'h000000, prot_q};
                    `FCC_OFF_STAT: prdata <= {24'h000000, bef_q, ccf_q, pvi_q, acc_q, 1'b0, blank_q, 2'b00};
                    `FCC_OFF_CMD:  prdata <= {24'h000000, bcmd_q};
                    default:       prdata <= (arr && !busy) ? {16'h0000, mem_rd} : 32'h0000_0000;
                endcase
            end
        end
    end

    // true when the word address lies in a protected half
    function addr_prot_b;
        input [8:0] a;
        input [7:0] p;
        begin
            addr_prot_b = ~p[`FCC_PR_OPEN] | (a[8] ? ~p[`FCC_PR_HDIS] : ~p[`FCC_PR_LDIS]);
        end
    endfunction
endmodule

//--- shared/fcc_defines.vh
`ifndef FCC_DEFINES_VH
`define FCC_DEFINES_VH
// register byte addresses
`define FCC_OFF_DIV      12'h000
`define FCC_OFF_CFG      12'h004
`define FCC_OFF_PROT     12'h008
`define FCC_OFF_STAT     12'h00C
`define FCC_OFF_CMD      12'h010
`define FCC_OFF_ADDR     12'h014
`define FCC_OFF_DATA     12'h018
`define FCC_OFF_ARRAY    12'h800
// status bit positions
`define FCC_ST_BLANK     2
`define FCC_ST_ACCESS_ERROR_FLAG    4
`define FCC_ST_PROTECTION_VIOLATION_FLAG     5
`define FCC_ST_CCF       6
`define FCC_ST_BEF       7
// config bit positions
`define FCC_CF_BEIE      7
`define FCC_CF_COMPLETE_IRQ_ENABLE      6
// protection bits
`define FCC_PR_OPEN      7
`define FCC_PR_HDIS      5
`define FCC_PR_LDIS      2
`define FCC_PROT_RST     8'hFF
// commands
`define FCC_CMD_VERIFY   8'h05
`define FCC_CMD_PROG     8'h20
`define FCC_CMD_SECT     8'h40
`define FCC_CMD_MASS     8'h41
// timing in pclk cycles; the divider does not scale them
`define FCC_T_PROG       16'd20
`define FCC_T_SECT       16'd200
`define FCC_T_MASS       16'd400
// array geometry: words
`define FCC_AW           9
`define FCC_DEPTH        512
`endif

//--- test/fcc_apb_master.sv
`timescale 1ns/1ns
`include "fcc_defines.vh"
module fcc_apb_master (
    input  wire        pclk,
    input  wire        pready,
    input  wire [31:0] prdata,
    output reg         psel,
    output reg         penable,
    output reg         pwrite,
    output reg  [11:0] paddr,
    output reg  [31:0] pwdata,
    output reg  [3:0]  pstrb
);
    initial begin
        {psel, penable, pwrite, paddr, pwdata, pstrb} = 0;
    end
    task xfer(input w, input [11:0] a, input [31:0] d, input [3:0] s);
        begin
            @(posedge pclk);
            {psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'b10, w, a, d, s};
            @(posedge pclk);
            penable <= 1'b1;
            do @(posedge pclk); while (pready !== 1'b1);
            psel <= 1'b0;
            penable <= 1'b0;
            pwdata <= ~d;
        end
    endtask
    task wr(input [11:0] a, input [31:0] d, input [3:0] s);
        xfer(1'b1, a, d, s);
    endtask
    task rd(input [11:0] a, output [31:0] v);
        begin
            xfer(1'b0, a, 32'h0000_0000, 4'h0);
            // taken at the edge that saw pready high
            v = prdata;
        end
    endtask
    // array word, then command, then launch
    task cmd(input [11:0] a, input [15:0] d, input [7:0] c);
        begin
            wr(a, {16'h0000, d}, 4'b0011);
            wr(`FCC_OFF_CMD, {24'h00_0000, c}, 4'hf);
            wr(`FCC_OFF_STAT, 32'h0000_0080, 4'hf);
        end
    endtask
endmodule

//--- test/fcc_ctrl_properties.sv
`timescale 1ns/1ns
`include "fcc_defines.vh"
module fcc_chk (
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire        stop_mode,
    input wire        irq,
    input wire        high_voltage_on
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire acc = psel && penable;
    chk_write_ready: assert property (acc && pwrite |-> pready) else $error("write not ready");
    chk_read_wait: assert property (acc && !pwrite && !pready |=> pready)
        else $error("read wait too long");
    chk_no_slverr: assert property (!pslverr) else $error("slave error");
    chk_rdata_hold: assert property (!(acc && !pwrite) |=> $stable(prdata))
        else $error("prdata moved without read");
    chk_stop_hv_off: assert property ($rose(stop_mode) |-> ##[0:2] !high_voltage_on)
        else $error("high voltage kept in stop");
    chk_stop_hv_hold: assert property (stop_mode [*3] |-> !high_voltage_on)
        else $error("high voltage on during stop");
    chk_stop_exit_idle: assert property ($fell(stop_mode) |-> !high_voltage_on [*3])
        else $error("buffered command ran after stop");
    chk_irq_masked: assert property (acc && pwrite && paddr == `FCC_OFF_CFG && pwdata[7:6] == 2'b00 |=> !irq)
        else $error("irq with enables off");
    chk_hv_min_run: assert property ($rose(high_voltage_on) |-> (high_voltage_on || stop_mode) [*8])
        else $error("operation ended too soon");
    cover property (acc && pwrite && paddr == `FCC_OFF_STAT && pwdata[7]);
    cover property ($rose(high_voltage_on));
    cover property ($rose(stop_mode) && high_voltage_on);
endmodule

//--- test/tb_top.sv
`timescale 1ns/1ns
`include "fcc_defines.vh"
module tb_top;
    reg         pclk = 0;
    reg         presetn = 0;
    reg         stop_mode = 0;
    wire        psel, penable, pwrite, pready, pslverr, irq, hv;
    wire [11:0] paddr;
    wire [31:0] pwdata, prdata;
    wire [3:0]  pstrb;
    reg  [31:0] v;
    integer     n_fail = 0;
    integer     tests_run = 0;
    always #10 pclk = ~pclk;
    fcc_apb_master fcc_apb_master_inst (.pclk(pclk), .pready(pready), .prdata(prdata), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb));
    fcc_ctrl fcc_ctrl_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .stop_mode(stop_mode), .background_debug_mode(1'b0), .secured(1'b0), .special_single_chip(1'b0),
        .secure_source(1'b1), .irq(irq), .high_voltage_on(hv));
    task chk(input [31:0] seen, input [31:0] exp);
        begin
            tests_run = tests_run + 1;
            if (seen !== exp) begin
                n_fail = n_fail + 1;
                $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
            end
        end
    endtask
    task rdc(input [11:0] a, input [31:0] m, input [31:0] e);
        begin
            fcc_apb_master_inst.rd(a, v);
            chk(v & m, e);
        end
    endtask
    task wr(input [11:0] a, input [31:0] d);
        fcc_apb_master_inst.wr(a, d, 4'hf);
    endtask
    // poll a status bit until set, bounded
    task poll(input integer b);
        integer k;
        begin
            k = 0;
            v = 0;
            while (v[b] !== 1'b1 && k < 600) begin
                fcc_apb_master_inst.rd(`FCC_OFF_STAT, v);
                k = k + 1;
            end
            chk({31'h0, v[b]}, 32'h1);
        end
    endtask
    // expect access error, then clear it with a one
    task acc_chk;
        begin
            rdc(`FCC_OFF_STAT, 32'h10, 32'h10);
            wr(`FCC_OFF_STAT, 32'h0000_0010);
            rdc(`FCC_OFF_STAT, 32'h10, 32'h00);
        end
    endtask
    task tally_and_finish;
        begin
            $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
            if (n_fail == 0 && tests_run > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask
    initial begin
        #1_000_000;
        n_fail = n_fail + 1;
        tally_and_finish;
    end
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rdc(`FCC_OFF_STAT, 32'hF0, 32'hC0);
        rdc(`FCC_OFF_PROT, 32'hFF, 32'hFF);
        rdc(`FCC_OFF_DIV, 32'h100, 32'h000);
        fcc_apb_master_inst.wr(`FCC_OFF_ARRAY, 32'h0, 4'b0011);
        acc_chk;
        wr(`FCC_OFF_DIV, 32'h0000_0004);
        rdc(`FCC_OFF_DIV, 32'h100, 32'h100);
        fcc_apb_master_inst.wr(12'h801, 32'h0, 4'b0011);
        acc_chk;
        fcc_apb_master_inst.wr(`FCC_OFF_ARRAY, 32'h0, 4'b0011);
        wr(`FCC_OFF_CMD, 32'h0000_0077);
        acc_chk;
        fcc_apb_master_inst.wr(`FCC_OFF_ARRAY, 32'h0, 4'b0011);
        wr(`FCC_OFF_CMD, 32'h0000_0020);
        wr(`FCC_OFF_STAT, 32'h0000_0000);
        acc_chk;
        $display("test sequence errors done");
        fcc_apb_master_inst.cmd(`FCC_OFF_ARRAY, 16'h0000, `FCC_CMD_MASS);
        poll(`FCC_ST_CCF);
        fcc_apb_master_inst.cmd(`FCC_OFF_ARRAY, 16'h0000, `FCC_CMD_VERIFY);
        poll(`FCC_ST_CCF);
        rdc(`FCC_OFF_STAT, 32'h04, 32'h04);
        fcc_apb_master_inst.cmd(12'h80A, 16'h1234, `FCC_CMD_PROG);
        poll(`FCC_ST_BEF);
        fcc_apb_master_inst.cmd(12'h80C, 16'h00F0, `FCC_CMD_PROG);
        rdc(`FCC_OFF_STAT, 32'h40, 32'h00);
        wr(`FCC_OFF_CFG, 32'h0000_0040);
        poll(`FCC_ST_CCF);
        chk({31'h0, irq}, 32'h1);
        wr(`FCC_OFF_CFG, 32'h0000_0000);
        rdc(12'h80A, 32'hFFFF, 32'h1234);
        rdc(12'h80C, 32'hFFFF, 32'h00F0);
        fcc_apb_master_inst.cmd(`FCC_OFF_ARRAY, 16'h0000, `FCC_CMD_VERIFY);
        poll(`FCC_ST_CCF);
        rdc(`FCC_OFF_STAT, 32'h04, 32'h00);
        fcc_apb_master_inst.cmd(12'h9FE, 16'h5555, `FCC_CMD_SECT);
        poll(`FCC_ST_CCF);
        rdc(12'h80A, 32'hFFFF, 32'hFFFF);
        fcc_apb_master_inst.cmd(12'hBFE, 16'h0F0F, `FCC_CMD_PROG);
        poll(`FCC_ST_CCF);
        fcc_apb_master_inst.cmd(`FCC_OFF_ARRAY, 16'h0000, `FCC_CMD_VERIFY);
        poll(`FCC_ST_CCF);
        rdc(`FCC_OFF_STAT, 32'h04, 32'h00);
        rdc(12'hBFE, 32'hFFFF, 32'h0F0F);
        $display("test commands done");
        wr(`FCC_OFF_PROT, 32'h0000_00FB);
        fcc_apb_master_inst.cmd(12'h80A, 16'h0000, `FCC_CMD_PROG);
        rdc(`FCC_OFF_STAT, 32'h20, 32'h20);
        rdc(12'h80A, 32'hFFFF, 32'hFFFF);
        wr(`FCC_OFF_STAT, 32'h0000_0030);
        rdc(`FCC_OFF_STAT, 32'h30, 32'h00);
        fcc_apb_master_inst.cmd(12'hA00, 16'h0000, `FCC_CMD_SECT);
        repeat (10) @(posedge pclk);
        stop_mode <= 1'b1;
        rdc(`FCC_OFF_STAT, 32'h50, 32'h50);
        stop_mode <= 1'b0;
        rdc(`FCC_OFF_STAT, 32'h80, 32'h80);
        fcc_apb_master_inst.cmd(12'hA02, 16'h0000, `FCC_CMD_PROG);
        poll(`FCC_ST_CCF);
        rdc(12'hA02, 32'hFFFF, 32'hFFFF);
        $display("test protection and stop done");
        tally_and_finish;
    end
endmodule
bind fcc_ctrl fcc_chk fcc_chk_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .stop_mode(stop_mode), .irq(irq), .high_voltage_on(high_voltage_on));
